// ### include/sbc_pkg.sv
/*
 package for the sensorless commutation sequencer: drive codes, state
 encodings and timer figures.
 assumes a 250 MHz clock; capacitor ramps become digital counters.
*/
package sbc_pkg;
	// one phase drive code: high impedance, sourcing, sinking
	typedef enum logic [1:0] {
		SBC_Z = 2'h0,
		SBC_H = 2'h1,
		SBC_L = 2'h2
	} sbc_drive_t;

	// six drive states, one-hot
	typedef enum logic [5:0] {
		SBC_S1 = 6'h01,
		SBC_S2 = 6'h02,
		SBC_S3 = 6'h04,
		SBC_S4 = 6'h08,
		SBC_S5 = 6'h10,
		SBC_S6 = 6'h20
	} sbc_state_t;

	// step watchdog timer phases, one-hot
	typedef enum logic [3:0] {
		SBC_TI_IDLE = 4'h1,
		SBC_TI_FAST = 4'h2,
		SBC_TI_SLOW = 4'h4,
		SBC_TI_DONE = 4'h8
	} sbc_ti_t;

	localparam int SBC_CLK_MHZ      = 250;
	// start oscillator period in microseconds
	localparam int SBC_START_US     = 500_000;
	localparam int SBC_START_CYC    = SBC_START_US * SBC_CLK_MHZ;
	// fast internal delay phase in nanoseconds
	localparam int SBC_FAST_NS      = 400;
	localparam int SBC_FAST_CYC     = (SBC_FAST_NS * SBC_CLK_MHZ + 999) / 1000;
	// watchdog interval in microseconds
	localparam int SBC_WDOG_US      = 3_800;
	localparam int SBC_WDOG_CYC     = SBC_WDOG_US * SBC_CLK_MHZ;
	// measurement timer width; full scale is the maximum delay
	localparam int SBC_CNT_W        = 24;
	localparam logic [23:0] SBC_CNT_FULL = 24'hFF_FFFF;
	localparam logic [23:0] SBC_CNT_ZERO = 24'h00_0000;
endpackage : sbc_pkg

// ### verilog/sbc_commutator.sv
/*
 sensorless bldc commutation sequencer: six-step drive, back-emf channel
 selection, adaptive delay, start oscillator, step watchdog, speed pulse.
 assumes comparator and flyback inputs are synchronous to clk and glitch free.
*/
`timescale 1ns/1ps
module sbc_commutator #(
	parameter int START_CYC = sbc_pkg::SBC_START_CYC,
	parameter int WDOG_CYC  = sbc_pkg::SBC_WDOG_CYC,
	parameter int CNT_W     = sbc_pkg::SBC_CNT_W
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [2:0]       emf_cmp,
	input  wire logic             flyback,
	output sbc_pkg::sbc_drive_t   phase_out_a,
	output sbc_pkg::sbc_drive_t   phase_out_b,
	output sbc_pkg::sbc_drive_t   phase_out_c,
	output logic                  speed_pulse_out_oe,
	output logic                  speed_pulse_out,
	output logic                  commutate
);
	import sbc_pkg::*;

	sbc_state_t           state_r;
	sbc_state_t           state_nxt;
	sbc_ti_t              ti_r;
	logic [CNT_W-1:0]     measure_r;   // delay_measure_timer
	logic [CNT_W-1:0]     repeat_r;    // delay_repeat_timer
	logic [CNT_W-1:0]     delay_r;     // countdown after a crossing
	logic                 delay_run_r;
	logic                 half_r;      // extra cycle after the countdown reaches zero, gates delay_end
	logic [31:0]          start_r;     // start_osc_timer
	logic [31:0]          wdog_r;      // step_watchdog_timer
	logic                 sel_prev_r;
	logic                 speed_r;
	logic                 measure_ovf_r;

	// drive pattern per state
	function automatic logic [5:0] sbc_drive(input sbc_state_t s);
		case (s)
			SBC_S1:  sbc_drive = {SBC_Z, SBC_L, SBC_H};
			SBC_S2:  sbc_drive = {SBC_H, SBC_L, SBC_Z};
			SBC_S3:  sbc_drive = {SBC_H, SBC_Z, SBC_L};
			SBC_S4:  sbc_drive = {SBC_Z, SBC_H, SBC_L};
			SBC_S5:  sbc_drive = {SBC_L, SBC_H, SBC_Z};
			SBC_S6:  sbc_drive = {SBC_L, SBC_Z, SBC_H};
			default: sbc_drive = {SBC_Z, SBC_Z, SBC_Z};
		endcase
	endfunction : sbc_drive

	// comparator of the floating phase in a drive pattern
	function automatic logic sbc_pick(input logic [5:0] d, input logic [2:0] e);
		if (d[5:4] == SBC_Z) begin
			sbc_pick = e[0];
		end else if (d[3:2] == SBC_Z) begin
			sbc_pick = e[1];
		end else begin
			sbc_pick = e[2];
		end
	endfunction : sbc_pick

	// floating phase comparator and its expected polarity after the crossing
	wire logic [5:0] drv_cur   = sbc_drive(state_r);
	wire logic [5:0] drv_nxt   = sbc_drive(state_nxt);
	wire logic       sel_emf   = sbc_pick(drv_cur, emf_cmp);
	wire logic       sel_nxt   = sbc_pick(drv_nxt, emf_cmp); // primes the edge detector on a step
	wire logic       rising    = state_r[0] | state_r[2] | state_r[4];
	wire logic       emf_right = rising ? sel_emf : ~sel_emf;
	wire logic       zero_x    = (sel_emf != sel_prev_r) && emf_right && !flyback && !delay_run_r;
	wire logic       zero_ok   = zero_x && (ti_r != SBC_TI_DONE);
	wire logic       delay_end = delay_run_r && (delay_r == '0) && half_r;
	wire logic       start_hit = (start_r >= 32'(START_CYC - 1));
	wire logic       step      = delay_end || start_hit;
	wire logic       wdog_end  = (wdog_r >= 32'(WDOG_CYC - 1));

	// next state in fixed order
	always_comb begin
		case (state_r)
			SBC_S1:  state_nxt = SBC_S2;
			SBC_S2:  state_nxt = SBC_S3;
			SBC_S3:  state_nxt = SBC_S4;
			SBC_S4:  state_nxt = SBC_S5;
			SBC_S5:  state_nxt = SBC_S6;
			SBC_S6:  state_nxt = SBC_S1;
			default: state_nxt = SBC_S1;
		endcase
	end

	// drive state and outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r     <= SBC_S1;
			phase_out_a <= SBC_Z;
			phase_out_b <= SBC_Z;
			phase_out_c <= SBC_Z;
			commutate   <= 1'b0;
		end else begin
			commutate <= step;
			if (step) begin
				state_r     <= state_nxt;
				phase_out_a <= sbc_drive_t'(drv_nxt[5:4]);
				phase_out_b <= sbc_drive_t'(drv_nxt[3:2]);
				phase_out_c <= sbc_drive_t'(drv_nxt[1:0]);
			end else begin
				phase_out_a <= sbc_drive_t'(drv_cur[5:4]);
				phase_out_b <= sbc_drive_t'(drv_cur[3:2]);
				phase_out_c <= sbc_drive_t'(drv_cur[1:0]);
			end
		end
	end

	// start oscillator, cleared by every commutation
	always_ff @(posedge clk) begin
		if (!nrst || step) begin
			start_r <= 32'h0000_0000;
		end else begin
			start_r <= start_r + 32'h0000_0001;
		end
	end

	// measurement timer: up over a period, paused in flyback
	always_ff @(posedge clk) begin
		if (!nrst || step) begin
			measure_r     <= '0;
			measure_ovf_r <= 1'b0;
		end else if (!flyback) begin
			if (measure_r == {CNT_W{1'b1}}) begin
				measure_ovf_r <= 1'b1;
			end else begin
				measure_r <= measure_r + 1'b1;
			end
		end
	end

	// repeat timer holds half the last measured period, loaded on each step
	always_ff @(posedge clk) begin
		if (!nrst) begin
			repeat_r <= '0;
		end else if (step) begin
			repeat_r <= measure_r >> 1;
		end
	end

	// delay countdown from half of (repeat_r | measure_r), one count per clock, full scale when slow
	always_ff @(posedge clk) begin
		if (!nrst || step) begin
			delay_run_r <= 1'b0;
			delay_r     <= '0;
			half_r      <= 1'b0;
		end else if (zero_ok) begin
			delay_run_r <= 1'b1;
			delay_r     <= measure_ovf_r ? {CNT_W{1'b1}} : (repeat_r | measure_r) >> 1;
			half_r      <= 1'b0;
		end else if (delay_run_r && delay_r != '0) begin
			delay_r <= delay_r - 1'b1;
		end else if (delay_run_r) begin
			half_r <= 1'b1;
		end
	end

	// step watchdog: fast delay, then slow while emf wrong
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ti_r   <= SBC_TI_IDLE;
			wdog_r <= 32'h0000_0000;
		end else begin
			case (ti_r)
				SBC_TI_IDLE: begin
					wdog_r <= 32'h0000_0000;
					if (step) ti_r <= SBC_TI_FAST;
				end
				SBC_TI_FAST: begin
					wdog_r <= wdog_r + 32'h0000_0001;
					if (wdog_r >= 32'(SBC_FAST_CYC - 1)) begin
						wdog_r <= 32'h0000_0000;
						ti_r   <= emf_right ? SBC_TI_IDLE : SBC_TI_SLOW;
					end
				end
				SBC_TI_SLOW: begin
					wdog_r <= wdog_r + 32'h0000_0001;
					if (emf_right) ti_r <= SBC_TI_IDLE;
					else if (wdog_end) ti_r <= SBC_TI_DONE;
				end
				SBC_TI_DONE: begin
					wdog_r <= 32'h0000_0000;
					if (step) ti_r <= SBC_TI_FAST;
				end
				default: ti_r <= SBC_TI_IDLE;
			endcase
		end
	end

	// speed pulse toggles on each crossing taken while the watchdog has not run out; open collector pulls low only
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sel_prev_r         <= 1'b0;
			speed_r            <= 1'b0;
			speed_pulse_out    <= 1'b0;
			speed_pulse_out_oe <= 1'b0;
		end else begin
			sel_prev_r         <= step ? sel_nxt : sel_emf;
			speed_r            <= speed_r ^ zero_ok;
			speed_pulse_out    <= 1'b0;
			speed_pulse_out_oe <= speed_r;
		end
	end
endmodule : sbc_commutator

// ### sim/sbc_motor_model.sv
/*
 motor winding model: back-emf comparators and flyback pulse per step.
 assumes the sequencer's commutate pulse marks each step.
*/
`timescale 1ns/1ps
module sbc_motor_model (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  sbc_pkg::sbc_drive_t phase_out_a,
	input  sbc_pkg::sbc_drive_t phase_out_b,
	input  sbc_pkg::sbc_drive_t phase_out_c,
	input  wire logic          commutate,
	input  wire logic          run,
	input  wire logic          late,
	input  wire logic          junk,
	output logic [2:0]         emf_cmp,
	output logic               flyback
);
	import sbc_pkg::*;
	logic [1:0] ph [3];
	logic [7:0] t_r;
	logic       tog_r;
	assign ph[0] = phase_out_a;
	assign ph[1] = phase_out_b;
	assign ph[2] = phase_out_c;
	// cycles since the last step, saturating
	always_ff @(posedge clk) begin
		t_r <= (!nrst || commutate) ? 8'h00 : ((t_r == 8'hff) ? t_r : t_r + 8'h01);
		tog_r <= !nrst ? 1'b0 : ~tog_r;
	end
	// diode pulse in the step cycle and for three cycles after it
	assign flyback = (t_r < 8'h03) || commutate;
	// emf turns once the rotor has moved far enough; held back in the step cycle
	wire logic turned = run && !commutate && (t_r >= (late ? 8'h6E : 8'h14));
	// floating phase recovers after 20 cycles (110 when late) when turning; driven phases may chatter
	for (genvar i = 0; i < 3; i++) begin : g_ph
		assign emf_cmp[i] = (ph[i] != SBC_Z) ? (junk ? tog_r : ph[i] == SBC_H)
			: ((ph[(i + 1) % 3] == SBC_L) ~^ turned);
	end
endmodule : sbc_motor_model

// ### sim/sbc_commutator_checker.sv
/*
 assertions on the sequencer's ports.
 assumes one clock domain and the sbc_pkg drive codes.
*/
`timescale 1ns/1ps
module sbc_commutator_checker #(
	parameter int START_CYC = 200
) (
	input wire logic           clk,
	input wire logic           nrst,
	input wire logic [2:0]     emf_cmp,
	input wire logic           flyback,
	input sbc_pkg::sbc_drive_t phase_out_a,
	input sbc_pkg::sbc_drive_t phase_out_b,
	input sbc_pkg::sbc_drive_t phase_out_c,
	input wire logic           speed_pulse_out_oe,
	input wire logic           speed_pulse_out,
	input wire logic           commutate
);
	import sbc_pkg::*;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	// drive pattern to state number, zero when not legal
	function automatic logic [2:0] idx(input logic [5:0] c);
		case (c)
			6'h09: return 3'h1;
			6'h18: return 3'h2;
			6'h12: return 3'h3;
			6'h06: return 3'h4;
			6'h24: return 3'h5;
			6'h21: return 3'h6;
			default: return 3'h0;
		endcase
	endfunction : idx
	wire logic [2:0] st = idx({phase_out_a, phase_out_b, phase_out_c});
	// cycles since the last commutation
	assign cnt_nxt = commutate ? 32'h0 : cnt_r + 32'h1;
	always_ff @(posedge clk) cnt_r <= nrst ? cnt_nxt : 32'h0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence step_s;
		$past(st) != 3'h0 && st != $past(st);
	endsequence
	legal_drive_a: assert property ($past(nrst) |-> st != 3'h0) else $error("bad drive");
	drive_order_a: assert property (step_s |-> st == ($past(st) % 6) + 1) else $error("order");
	step_pulse_a: assert property (step_s |-> commutate) else $error("no pulse");
	pulse_single_a: assert property (commutate |=> !commutate) else $error("long pulse");
	pulse_cause_a: assert property (commutate |-> step_s) else $error("pulse no step");
	start_bound_a: assert property (cnt_r <= START_CYC + 2) else $error("no start step");
	speed_data_a: assert property (speed_pulse_out == 1'b0) else $error("speed data");
	toggle_step_a: assert property ($past(nrst) && $changed(speed_pulse_out_oe)
		|-> ##[1:300] commutate) else $error("toggle no step");
endmodule : sbc_commutator_checker
bind sbc_commutator sbc_commutator_checker #(.START_CYC(START_CYC)) sbc_commutator_checker_inst (
	.clk(clk), .nrst(nrst), .emf_cmp(emf_cmp), .flyback(flyback), .phase_out_a(phase_out_a),
	.phase_out_b(phase_out_b), .phase_out_c(phase_out_c), .speed_pulse_out(speed_pulse_out),
	.speed_pulse_out_oe(speed_pulse_out_oe), .commutate(commutate));

// ### sim/sbc_commutator_test.sv
/*
 testbench: start oscillator stepping, then emf driven running.
 assumes the motor model and shortened counts.
*/
`timescale 1ns/1ps
module sbc_commutator_test;
	import sbc_pkg::*;
	localparam int START_CYC = 200;
	logic clk = 0, nrst = 0, run = 0, junk = 0, late = 0;
	wire logic [2:0] emf_cmp;
	wire logic flyback, oe, spd, comm;
	sbc_drive_t pa, pb, pc;
	int n_mismatch = 0, num_checks = 0;
	logic [5:0] tbl [6] = '{6'h09, 6'h18, 6'h12, 6'h06, 6'h24, 6'h21};
	always #2 clk = ~clk;
	sbc_commutator #(.START_CYC(START_CYC), .WDOG_CYC(50), .CNT_W(8)) sbc_commutator_inst (
		.clk(clk), .nrst(nrst), .emf_cmp(emf_cmp), .flyback(flyback), .phase_out_a(pa),
		.phase_out_b(pb), .phase_out_c(pc), .speed_pulse_out_oe(oe), .speed_pulse_out(spd),
		.commutate(comm));
	sbc_motor_model sbc_motor_model_inst (.clk(clk), .nrst(nrst), .phase_out_a(pa),
		.phase_out_b(pb), .phase_out_c(pc), .commutate(comm), .run(run), .late(late), .junk(junk),
		.emf_cmp(emf_cmp), .flyback(flyback));
	task chk_st(input logic [5:0] got, input logic [5:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t drive %h expected %h", $time, got, exp);
		end
	endtask : chk_st
	task chk_ok(input logic ok, input string what);
		num_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : chk_ok
	task do_reset;
		nrst = 0;
		repeat (3) @(posedge clk);
		#1 nrst = 1;
	endtask : do_reset
	// edges up to the next commutate pulse, capped
	task wait_comm(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (comm !== 1'b1 && n < START_CYC + 10);
	endtask : wait_comm
	// chattering driven phases must not step; start oscillator walks the table
	task t_start;
		int n;
		junk = 1;
		do_reset;
		@(posedge clk);
		#1 chk_st({pa, pb, pc}, tbl[0]);
		for (int i = 1; i <= 6; i++) begin
			wait_comm(n);
			chk_ok(n >= START_CYC - 3 && n <= START_CYC + 3, "start period");
			chk_st({pa, pb, pc}, tbl[i % 6]);
		end
		chk_ok(oe === 1'b0, "toggle without crossing");
		$display("test start done");
	endtask : t_start
	// turning motor: crossings drive steps and speed toggles
	task t_run;
		int steps, togs;
		logic last;
		run = 1;
		junk = 0;
		do_reset;
		steps = 0;
		togs = 0;
		last = oe;
		repeat (3000) begin
			@(posedge clk);
			#1 steps += (comm === 1'b1);
			togs += (oe !== last);
			last = oe;
		end
		chk_ok(steps > 3000 / START_CYC + 4, "emf steps");
		chk_ok(togs >= steps && togs <= steps + 1, "speed toggles");
		$display("test run done");
	endtask : t_run
	// emf back only after the watchdog ran out: no toggle, start oscillator steps
	task t_watch;
		int n;
		logic last;
		run = 0;
		junk = 0;
		late = 0;
		do_reset;
		wait_comm(n);
		repeat (170) @(posedge clk);
		#1 run = 1;
		last = oe;
		wait_comm(n);
		chk_ok(n >= START_CYC - 173 && n <= START_CYC - 167, "step after expiry");
		chk_ok(oe === last, "toggle after expiry");
		last = oe;
		wait_comm(n);
		chk_ok(n > 20 && n < START_CYC - 10, "emf step after restart");
		chk_ok(oe !== last, "no toggle after restart");
		$display("test watch done");
	endtask : t_watch
	// emf back late, inside the slow watchdog phase: still a valid crossing
	task t_late;
		int n;
		logic last;
		run = 1;
		junk = 0;
		late = 1;
		do_reset;
		repeat (4) begin
			last = oe;
			wait_comm(n);
			chk_ok(n > 100 && n < START_CYC - 5, "late emf step");
			chk_ok(oe !== last, "late emf toggle");
		end
		late = 0;
		$display("test late done");
	endtask : t_late
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	initial begin
		t_start;
		t_run;
		t_watch;
		t_late;
		summarize;
	end
	// hang guard, about twice the expected run
	initial begin
		#44000 n_mismatch++;
		summarize;
	end
endmodule : sbc_commutator_test
